//--- rtl/timer_counter_pkg.sv
// Shared constants for the 8/16-bit timer/counter.
// Assumes an APB slave with byte addresses and 32-bit data.
package timer_counter_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL1 = 8'h04;
	localparam logic [7:0] OFF_LOW = 8'h08;
	localparam logic [7:0] OFF_HIGH = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	// First control register fields
	localparam int CTRL0_EN = 7;
	localparam int CTRL0_OUT = 5;
	localparam int CTRL0_WIDTH = 4;
	localparam int CTRL0_OUTPS_HI = 3;
	// Second control register fields
	localparam int CTRL1_CS_HI = 7;
	localparam int CTRL1_CS_LO = 5;
	localparam int CTRL1_ASYNC = 4;
	localparam int CTRL1_CKPS_HI = 3;
	// Status register fields
	localparam int STAT_FLAG = 0;
	localparam int STAT_IE = 1;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] LOW_RST = 8'h00;
	localparam logic [7:0] HIGH_RST = 8'hFF;
	localparam logic [7:0] PERIOD_RST = 8'hFF;
	// Scaler sizes
	localparam int PRESCALE_W = 15;
	localparam int POSTSCALE_W = 4;
	localparam int RATIO_W = 4;
	// Last quarter-counter value; four system clocks per instruction cycle
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	// Clock source encodings
	typedef enum logic [2:0] {
		CS_EXT_TRUE = 3'h0,
		CS_EXT_INV = 3'h1,
		CS_QUARTER = 3'h2,
		CS_HF_OSC = 3'h3,
		CS_LF_OSC = 3'h4,
		CS_MF_OSC = 3'h5,
		CS_SEC_OSC = 3'h6,
		CS_LOGIC_CELL = 3'h7
	} clk_sel_t;
endpackage

//--- rtl/prescaler.sv
// Power-of-two prescaler for the counter clock.
// Assumes tick is a one-cycle pulse per rising source edge.
`timescale 1ns/10ps
module prescaler
	import timer_counter_pkg::*;
#(
	parameter int WIDTH = PRESCALE_W
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic clear,
	input wire logic [RATIO_W-1:0] ratio,
	// Ticks
	input wire logic tick,
	output logic out_tick
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] mask;

	// Ratio 0 gives an all-zero mask, so every tick passes
	assign mask = WIDTH'((32'h0000_0001 << ratio) - 32'h0000_0001);
	assign out_tick = tick && ((count & mask) == mask);

	// Not visible to software; only clear or presetn resets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end
endmodule

//--- rtl/postscaler.sv
// Output divider: passes one event out of (field + 1).
// Assumes evt is a one-cycle pulse.
`timescale 1ns/10ps
module postscaler
	import timer_counter_pkg::*;
#(
	parameter int WIDTH = POSTSCALE_W
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic clear,
	input wire logic [WIDTH-1:0] field,
	// Events
	input wire logic evt,
	output logic out_evt
);
	logic [WIDTH-1:0] count;

	assign out_evt = evt && (count == field);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (clear) begin
			count <= '0;
		end else if (evt) begin
			count <= out_evt ? '0 : count + 1'b1;
		end
	end
endmodule

//--- rtl/timer_counter.sv
// 8/16-bit timer/counter with APB register access.
// Assumes all source inputs are synchronous to pclk and change at
// most once per two pclk cycles; sleep_mode comes from the core.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module timer_counter
	import timer_counter_pkg::*;
(
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// APB answer
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock sources
	input wire logic ext_clk_in,
	input wire logic hf_osc,
	input wire logic lf_osc,
	input wire logic mf_osc,
	input wire logic sec_osc,
	input wire logic logic_cell_out,
	// Power state
	input wire logic sleep_mode,
	// Timer outputs
	output logic match_pulse,
	output logic timer_out,
	output logic timer_irq_flag,
	output logic wake_request
);
	function automatic logic addr_hit(input logic [7:0] a,
		input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = addr_hit(a, OFF_CTRL0) || addr_hit(a, OFF_CTRL1)
			|| addr_hit(a, OFF_LOW) || addr_hit(a, OFF_HIGH)
			|| addr_hit(a, OFF_STAT);
	endfunction

	// Registers
	logic module_enable;
	logic width_select;
	logic [3:0] output_divider_field;
	logic [2:0] clock_select_field;
	logic async_enable;
	logic [3:0] prescale_ratio_field;
	logic [7:0] count_low_byte;
	logic [7:0] count_high_buffer;
	logic irq_enable;

	// Counter state
	logic [7:0] high_true;
	logic [7:0] period_buf;
	logic [1:0] quarter_cnt;
	logic src_prev;
	logic sync_pending;

	// Combinational
	logic access;
	logic wr_commit;
	logic rd_commit;
	logic wr_ctrl0;
	logic wr_ctrl1;
	logic wr_low;
	logic wr_high;
	logic wr_stat;
	logic rd_low;
	logic scaler_clr;
	logic quarter_tick;
	logic src_level;
	logic src_rise;
	logic run;
	logic pre_tick;
	logic pre_out;
	logic count_evt;
	logic wrap_evt;
	logic post_evt;
	logic [31:0] next_prdata;

	assign access = psel && penable && pready;
	assign wr_commit = access && pwrite;
	assign rd_commit = access && !pwrite;
	assign wr_ctrl0 = wr_commit && addr_hit(paddr, OFF_CTRL0);
	assign wr_ctrl1 = wr_commit && addr_hit(paddr, OFF_CTRL1);
	assign wr_low = wr_commit && addr_hit(paddr, OFF_LOW);
	assign wr_high = wr_commit && addr_hit(paddr, OFF_HIGH);
	assign wr_stat = wr_commit && addr_hit(paddr, OFF_STAT);
	assign rd_low = rd_commit && addr_hit(paddr, OFF_LOW);

	// Reset is covered by the scalers' own asynchronous reset
	assign scaler_clr = wr_low || wr_ctrl0 || wr_ctrl1;

	// APB answers one cycle after setup, always zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= psel && !penable && !addr_mapped(paddr);
		end
	end

	always_comb begin
		next_prdata = '0;
		if (addr_hit(paddr, OFF_CTRL0)) begin
			next_prdata[CTRL0_EN] = module_enable;
			next_prdata[CTRL0_OUT] = timer_out;
			next_prdata[CTRL0_WIDTH] = width_select;
			next_prdata[CTRL0_OUTPS_HI:0] = output_divider_field;
		end else if (addr_hit(paddr, OFF_CTRL1)) begin
			next_prdata[CTRL1_CS_HI:CTRL1_CS_LO] = clock_select_field;
			next_prdata[CTRL1_ASYNC] = async_enable;
			next_prdata[CTRL1_CKPS_HI:0] = prescale_ratio_field;
		end else if (addr_hit(paddr, OFF_LOW)) begin
			next_prdata[7:0] = count_low_byte;
		end else if (addr_hit(paddr, OFF_HIGH)) begin
			next_prdata[7:0] = count_high_buffer;
		end else if (addr_hit(paddr, OFF_STAT)) begin
			next_prdata[STAT_FLAG] = timer_irq_flag;
			next_prdata[STAT_IE] = irq_enable;
		end
	end

	// Read data is sampled in setup, held through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= next_prdata;
		end
	end

	// First control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			module_enable <= CTRL_RST[CTRL0_EN];
			width_select <= CTRL_RST[CTRL0_WIDTH];
			output_divider_field <= CTRL_RST[CTRL0_OUTPS_HI:0];
		end else if (wr_ctrl0) begin
			module_enable <= pwdata[CTRL0_EN];
			width_select <= pwdata[CTRL0_WIDTH];
			output_divider_field <= pwdata[CTRL0_OUTPS_HI:0];
		end
	end

	// Second control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_select_field <= CTRL_RST[CTRL1_CS_HI:CTRL1_CS_LO];
			async_enable <= CTRL_RST[CTRL1_ASYNC];
			prescale_ratio_field <= CTRL_RST[CTRL1_CKPS_HI:0];
		end else if (wr_ctrl1) begin
			clock_select_field <= pwdata[CTRL1_CS_HI:CTRL1_CS_LO];
			async_enable <= pwdata[CTRL1_ASYNC];
			prescale_ratio_field <= pwdata[CTRL1_CKPS_HI:0];
		end
	end

	// Quarter system clock: one instruction cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quarter_cnt <= '0;
		end else begin
			quarter_cnt <= quarter_cnt + 1'b1;
		end
	end

	assign quarter_tick = (quarter_cnt == QUARTER_LAST);

	always_comb begin
		unique case (clk_sel_t'(clock_select_field))
			CS_EXT_TRUE: src_level = ext_clk_in;
			CS_EXT_INV: src_level = !ext_clk_in;
			CS_QUARTER: src_level = quarter_tick;
			CS_HF_OSC: src_level = hf_osc;
			CS_LF_OSC: src_level = lf_osc;
			CS_MF_OSC: src_level = mf_osc;
			CS_SEC_OSC: src_level = sec_osc;
			CS_LOGIC_CELL: src_level = logic_cell_out;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_prev <= 1'b0;
		end else begin
			src_prev <= src_level;
		end
	end

	assign src_rise = src_level && !src_prev;

	// Sleep stops the synchronous path; async keeps going
	assign run = module_enable && (async_enable || !sleep_mode);
	assign pre_tick = src_rise && run;

	prescaler #(
		.WIDTH(PRESCALE_W)
	) u_prescaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(scaler_clr),
		.ratio(prescale_ratio_field),
		.tick(pre_tick),
		.out_tick(pre_out)
	);

	// In sync mode a prescaler edge waits for the next quarter tick,
	// so the count rate can never exceed one per instruction cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_pending <= 1'b0;
		end else if (!run || async_enable || scaler_clr) begin
			sync_pending <= 1'b0;
		end else if (quarter_tick) begin
			sync_pending <= 1'b0;
		end else if (pre_out) begin
			sync_pending <= 1'b1;
		end
	end

	always_comb begin
		if (!run) begin
			count_evt = 1'b0;
		end else if (async_enable) begin
			count_evt = pre_out;
		end else begin
			count_evt = quarter_tick && (sync_pending || pre_out);
		end
	end

	// Period match in 8-bit mode, all-ones wrap in 16-bit mode
	assign wrap_evt = count_evt && !wr_low && (width_select
		? (&{high_true, count_low_byte})
		: (count_low_byte == period_buf));

	// Counter and period buffer; a software write beats a count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_low_byte <= LOW_RST;
			high_true <= LOW_RST;
			period_buf <= PERIOD_RST;
		end else if (wr_low) begin
			count_low_byte <= pwdata[7:0];
			if (width_select) begin
				high_true <= count_high_buffer;
			end
		end else if (count_evt) begin
			if (width_select) begin
				{high_true, count_low_byte} <=
					{high_true, count_low_byte} + 16'h0001;
			end else if (wrap_evt) begin
				count_low_byte <= LOW_RST;
				period_buf <= count_high_buffer;
			end else begin
				count_low_byte <= count_low_byte + 8'h01;
			end
		end
	end

	// High byte register: period in 8-bit mode, buffer in 16-bit mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_high_buffer <= HIGH_RST;
		end else if (wr_high) begin
			count_high_buffer <= pwdata[7:0];
		end else if (rd_low && width_select) begin
			count_high_buffer <= high_true;
		end
	end

	// Stays high for one prescaled period after the event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_pulse <= 1'b0;
		end else if (!module_enable) begin
			match_pulse <= 1'b0;
		end else if (count_evt) begin
			match_pulse <= wrap_evt;
		end
	end

	postscaler #(
		.WIDTH(POSTSCALE_W)
	) u_postscaler (
		.pclk(pclk),
		.presetn(presetn),
		.clear(scaler_clr),
		.field(output_divider_field),
		.evt(wrap_evt),
		.out_evt(post_evt)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_out <= 1'b0;
		end else if (post_evt) begin
			timer_out <= !timer_out;
		end
	end

	// Sticky flag; a new event in the clearing cycle keeps it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_irq_flag <= 1'b0;
		end else if (post_evt) begin
			timer_irq_flag <= 1'b1;
		end else if (wr_stat && pwdata[STAT_FLAG]) begin
			timer_irq_flag <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable <= 1'b0;
		end else if (wr_stat) begin
			irq_enable <= pwdata[STAT_IE];
		end
	end

	// Only an async timer can still be counting in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_request <= 1'b0;
		end else begin
			wake_request <= sleep_mode && async_enable
				&& timer_irq_flag && irq_enable;
		end
	end
endmodule

//--- bench/timer_counter_assertions.sv
// Checker for the timer/counter APB port and its event outputs.
// Sees only top-level ports; bound from the bench top file.
`timescale 1ns/10ps
module timer_counter_assertions
	import timer_counter_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sources and power
	input wire logic ext_clk_in,
	input wire logic hf_osc,
	input wire logic lf_osc,
	input wire logic mf_osc,
	input wire logic sec_osc,
	input wire logic logic_cell_out,
	input wire logic sleep_mode,
	// Outputs
	input wire logic match_pulse,
	input wire logic timer_out,
	input wire logic timer_irq_flag,
	input wire logic wake_request
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic clr_q;
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence event_s;
		match_pulse || $past(match_pulse);
	endsequence
	// Registered so the flag drop can be tied to the committed write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clr_q <= 1'b0;
		end else begin
			clr_q <= psel && penable && pready && pwrite &&
				paddr == OFF_STAT && pwdata[STAT_FLAG];
		end
	end
	ready_after_setup_a: assert property (setup_s |=> pready)
		else $error("ready missing after setup");
	ready_only_setup_a: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	slverr_decode_a: assert property (pready |->
		pslverr == (paddr > OFF_STAT || paddr[1:0] != 2'h0))
		else $error("error response on wrong address");
	err_data_zero_a: assert property (pready && pslverr && !pwrite |->
		prdata == 32'h0)
		else $error("refused read returned data");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=>
		$stable(prdata))
		else $error("read data moved without a read");
	flag_clear_a: assert property ($fell(timer_irq_flag) |-> clr_q)
		else $error("flag dropped without clear write");
	flag_cause_a: assert property ($rose(timer_irq_flag) |-> event_s)
		else $error("flag set without match");
	toggle_cause_a: assert property ($changed(timer_out) |-> event_s)
		else $error("output toggled without match");
	wake_cause_a: assert property (wake_request |->
		$past(sleep_mode && timer_irq_flag))
		else $error("wake without sleep and flag");
endmodule

//--- bench/tb_top.sv
// Bench for the timer/counter: APB master, clock sources, sleep.
// Sources are divided copies of pclk; both external selects share the quarter clock's rate.
`timescale 1ns/10ps
module tb_top;
	import timer_counter_pkg::*;
`define CMP(n, e, g) begin compares++; if ((g) !== (e)) begin \
	fail_count++; $display("unexpected %s exp %0h got %0h", n, e, g); \
	end end
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, r, x;
	logic pready, pslverr, match_pulse, timer_out, timer_irq_flag;
	logic wake_request, sleep_mode = 0, err;
	logic ext_clk_in, hf_osc, lf_osc, mf_osc, sec_osc, logic_cell_out;
	logic [7:0] dv = 0;
	int fail_count = 0, compares = 0, cyc = 0;
	int gap[8] = '{4, 4, 4, 8, 16, 32, 64, 128};
	timer_counter dut_u (.*);
	assign ext_clk_in = dv[1];
	assign hf_osc = dv[2];
	assign lf_osc = dv[3];
	assign mf_osc = dv[4];
	assign sec_osc = dv[5];
	assign logic_cell_out = dv[6];
	initial forever #12.5 pclk = ~pclk;
	always @(posedge pclk) begin
		dv <= dv + 8'h01;
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the bench timeout ends a slave that never answers
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_tog(output int n);
		logic l;
		l = timer_out;
		n = 0;
		while (timer_out === l && n < 6000) begin
			@(posedge pclk);
			n++;
		end
	endtask
	task automatic t_reset();
		apb(1'b0, OFF_CTRL0, 8'h00);
		`CMP("ctrl0", 32'h0, r)
		apb(1'b0, OFF_CTRL1, 8'h00);
		`CMP("ctrl1", 32'h0, r)
		apb(1'b0, OFF_LOW, 8'h00);
		`CMP("low", 32'h0, r)
		apb(1'b0, OFF_HIGH, 8'h00);
		`CMP("high", 32'hFF, r)
		apb(1'b0, 8'h14, 8'h00);
		`CMP("unmapped", 33'h100000000, {err, r})
		$display("reset test done");
	endtask
	task automatic t_hold16();
		apb(1'b1, OFF_CTRL1, 8'h50);
		apb(1'b1, OFF_CTRL0, 8'h10);
		apb(1'b1, OFF_HIGH, 8'h12);
		apb(1'b1, OFF_LOW, 8'h34);
		apb(1'b1, OFF_HIGH, 8'h56);
		repeat (40) @(posedge pclk);
		apb(1'b0, OFF_LOW, 8'h00);
		`CMP("held low", 32'h34, r)
		apb(1'b0, OFF_HIGH, 8'h00);
		`CMP("true high", 32'h12, r)
		`CMP("no match", 1'b0, match_pulse)
		$display("16-bit hold test done");
	endtask
	task automatic t_wrap16();
		int n;
		apb(1'b1, OFF_CTRL1, 8'h40);
		apb(1'b1, OFF_HIGH, 8'hFF);
		apb(1'b1, OFF_LOW, 8'hFD);
		// 1:1 postscaler, so the first wrap toggles timer_out
		apb(1'b1, OFF_CTRL0, 8'h90);
		wait_tog(n);
		`CMP("wrap seen", 1'b1, n < 60)
		apb(1'b0, OFF_LOW, 8'h00);
		`CMP("low after wrap", 1'b1, r < 32'h3)
		apb(1'b0, OFF_HIGH, 8'h00);
		`CMP("high after wrap", 32'h0, r)
		$display("16-bit wrap test done");
	endtask
	task automatic t_sleep();
		apb(1'b1, OFF_CTRL0, 8'h80);
		sleep_mode <= 1'b1;
		apb(1'b0, OFF_LOW, 8'h00);
		x = r;
		repeat (40) @(posedge pclk);
		apb(1'b0, OFF_LOW, 8'h00);
		`CMP("sync sleep", x, r)
		apb(1'b1, OFF_CTRL1, 8'h10);
		apb(1'b1, OFF_STAT, 8'h03);
		apb(1'b1, OFF_LOW, 8'hFD);
		repeat (60) @(posedge pclk);
		`CMP("wake", 1'b1, wake_request)
		sleep_mode <= 1'b0;
		apb(1'b1, OFF_CTRL0, 8'h00);
		apb(1'b1, OFF_STAT, 8'h01);
		// The clear lands at the commit edge; look one edge later
		@(posedge pclk);
		`CMP("flag cleared", 1'b0, timer_irq_flag)
		$display("sleep test done");
	endtask
	task automatic t_period(input logic [7:0] c, p, input logic [3:0] ps,
		input int e);
		int n;
		apb(1'b1, OFF_CTRL0, 8'h00);
		apb(1'b1, OFF_CTRL1, c);
		apb(1'b1, OFF_HIGH, p);
		apb(1'b1, OFF_LOW, 8'hFD);
		apb(1'b1, OFF_STAT, 8'h01);
		apb(1'b1, OFF_CTRL0, {4'h8, ps});
		wait_tog(n);
		wait_tog(n);
		`CMP("toggle gap", e, n)
		`CMP("match", 1'b1, match_pulse)
		`CMP("flag", 1'b1, timer_irq_flag)
		$display("period test done");
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_hold16();
		t_wrap16();
		t_sleep();
		for (int i = 0; i < 8; i++) begin
			t_period({i[2:0], 5'h10}, 8'h00, 4'h0, gap[i]);
		end
		t_period(8'h40, 8'h03, 4'h0, 16);
		t_period(8'h42, 8'h01, 4'h2, 96);
		t_period(8'h01, 8'h02, 4'h1, 48);
		final_report();
	end
endmodule
bind timer_counter timer_counter_assertions chk_u (.*);
